// *** hdl/csn_pkg.sv ***
package csn_pkg;

  // ---------------------------------------------------------------
  // register map (byte addresses on the apb bus)
  // ---------------------------------------------------------------
  localparam logic [7:0] CSN_OFF_CTRL = 8'h00;
  localparam logic [7:0] CSN_OFF_TA1  = 8'h04;
  localparam logic [7:0] CSN_OFF_GTB  = 8'h08;
  localparam logic [7:0] CSN_OFF_SEC  = 8'h0c;
  localparam logic [7:0] CSN_OFF_STAT = 8'h10;
  localparam logic [7:0] CSN_OFF_EVT  = 8'h14;
  localparam logic [7:0] CSN_OFF_CNT  = 8'h18;

  // ---------------------------------------------------------------
  // control field positions
  // ---------------------------------------------------------------
  localparam int CSN_CTRL_GLOB_EN  = 0;
  localparam int CSN_CTRL_CLASS_A  = 1;
  localparam int CSN_CTRL_CSTOP    = 2;
  localparam int CSN_CTRL_WARM_SPC = 3;
  localparam int CSN_CTRL_T0       = 4;
  localparam int CSN_CTRL_T1       = 5;

  // ---------------------------------------------------------------
  // first global byte after the t=15 indication (bit n is b(n+1))
  // ---------------------------------------------------------------
  localparam int CSN_GB_ANY   = 7;
  localparam int CSN_GB_USB   = 6;
  localparam int CSN_GB_CLF   = 5;
  localparam int CSN_GB_LOWZ  = 4;
  localparam int CSN_GB_SCHAN = 3;
  localparam int CSN_GB_P2P   = 2;
  localparam int CSN_GB_EMGT  = 1;
  localparam logic [7:0] CSN_GB_KNOWN = 8'hfe;

  // ---------------------------------------------------------------
  // event flag positions
  // ---------------------------------------------------------------
  localparam int CSN_EV_COLD = 0;
  localparam int CSN_EV_WARM = 1;
  localparam int CSN_EV_PPOK = 2;
  localparam int CSN_EV_PBAD = 3;
  localparam int CSN_EV_NUM  = 4;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] CSN_CTRL_RST   = 8'h10;
  localparam logic [7:0] CSN_FIDI_DEF   = 8'h11;
  localparam logic [7:0] CSN_TA1_RST    = 8'h11;
  localparam logic [7:0] CSN_GTB_RST    = 8'h00;
  localparam logic [7:0] CSN_SEC_RST    = 8'h00;
  localparam logic [3:0] CSN_PROTO_T0   = 4'h0;
  localparam logic [3:0] CSN_PROTO_T1   = 4'h1;

  typedef enum logic [1:0] {
    CSN_ST_OFF,
    CSN_ST_HOLD,
    CSN_ST_NEG,
    CSN_ST_RUN
  } csn_state_type;

endpackage

// *** hdl/csn_sync.sv ***
`timescale 1ns/1ps
module csn_sync (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic ce,
  input  wire logic async_in,
  output logic      sync_out
);
  logic meta_q;
  logic meta_d;
  logic sync_d;

  always_comb begin
    meta_d = ce ? async_in : meta_q;
    sync_d = ce ? meta_q : sync_out;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q   <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      meta_q   <= meta_d;
      sync_out <= sync_d;
    end
  end
endmodule

// *** hdl/csn_flag.sv ***
`timescale 1ns/1ps
module csn_flag (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic ce,
  input  wire logic set,
  input  wire logic clr,
  output logic      flag_q
);
  logic flag_d;

  // set wins over a clear in the same cycle so no event is lost
  always_comb begin
    flag_d = flag_q;
    if (ce && clr) begin
      flag_d = 1'b0;
    end
    if (ce && set) begin
      flag_d = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_q <= 1'b0;
    end else begin
      flag_q <= flag_d;
    end
  end
endmodule

// *** hdl/csn_session.sv ***
// Functional notes
// - zero global byte means no features; b5 low-impedance
// - b8 and b7 advertise inter-chip usb
// - b8 and b6 advertise contactless frontend link
// - b4 secure channel; b4+b3 secured units required
// - b8 and b2 advertise embedded management
// - global byte only reachable via t=15 indication
// - non-default parameters only after successful exchange
// - cold reset: negotiable mode, security cleared
// - warm reset: specific mode keeps protocol, rates
// - identical answer-to-reset after warm resets in session
// - warm reset also clears security status
// - beyond class a, clock stop must be allowed
// - card repeats characters on parity error in t=0
// - card supports at least one of t=0, t=1
`timescale 1ns/1ps
module csn_session (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        contact_on_pin,
  input  wire logic        card_rst_n_pin,
  input  wire logic        pps_valid,
  input  wire logic [3:0]  pps_proto,
  input  wire logic        pps1_present,
  input  wire logic [7:0]  pps1,
  input  wire logic        pps2_present,
  input  wire logic [7:0]  pps2,
  output logic             atr_start,
  output logic      [7:0]  atr_ta1,
  output logic      [7:0]  atr_glob_tb,
  output logic             atr_glob_present,
  output logic             atr_clkstop_ok,
  output logic      [1:0]  atr_protos,
  output logic             pps_done,
  output logic             pps_accept,
  output logic      [7:0]  cur_fidi,
  output logic      [3:0]  cur_proto,
  output logic             nondefault_ok,
  output logic             char_repeat_en,
  output logic      [7:0]  sec_status,
  output logic             mode_specific
);

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic vcc_s;
  logic rstn_s;
  logic vcc_prev_q;
  logic rstn_prev_q;

  csn_sync u_sync_vcc (
    .pclk     (pclk),
    .presetn  (presetn),
    .ce       (ce),
    .async_in (contact_on_pin),
    .sync_out (vcc_s)
  );

  csn_sync u_sync_rst (
    .pclk     (pclk),
    .presetn  (presetn),
    .ce       (ce),
    .async_in (card_rst_n_pin),
    .sync_out (rstn_s)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vcc_prev_q  <= 1'b0;
      rstn_prev_q <= 1'b0;
    end else if (ce) begin
      vcc_prev_q  <= vcc_s;
      rstn_prev_q <= rstn_s;
    end
  end

  logic vcc_rise;
  logic rst_release;
  logic cold_pend_q;
  logic is_cold;
  logic is_warm;

  assign vcc_rise    = vcc_s & ~vcc_prev_q;
  assign rst_release = vcc_s & rstn_s & ~rstn_prev_q;
  assign is_cold     = ce & rst_release & cold_pend_q;
  assign is_warm     = ce & rst_release & ~cold_pend_q;

  // ---------------------------------------------------------------
  // apb slave
  // ---------------------------------------------------------------
  logic [7:0]  ctrl_q;
  logic [7:0]  ctrl_d;
  logic [7:0]  ta1_q;
  logic [7:0]  ta1_d;
  logic [7:0]  gtb_q;
  logic [7:0]  gtb_d;
  logic [7:0]  cold_cnt_q;
  logic [7:0]  cold_cnt_d;
  logic [7:0]  warm_cnt_q;
  logic [7:0]  warm_cnt_d;
  logic [31:0] prdata_d;
  logic        pready_d;
  logic        pslverr_d;
  logic        wr_en;
  logic        mapped;
  logic        ro_reg;
  logic [csn_pkg::CSN_EV_NUM-1:0] evt_q;
  logic [csn_pkg::CSN_EV_NUM-1:0] evt_set;
  logic [csn_pkg::CSN_EV_NUM-1:0] evt_clr;
  logic [7:0]  stat_w;
  logic [5:0]  feat_w;

  // the access phase lasts two cycles; writes land at the pready edge
  assign wr_en  = ce & psel & penable & pready & pwrite & ~pslverr;
  assign mapped = (paddr == csn_pkg::CSN_OFF_CTRL) || (paddr == csn_pkg::CSN_OFF_TA1)
               || (paddr == csn_pkg::CSN_OFF_GTB)  || (paddr == csn_pkg::CSN_OFF_SEC)
               || (paddr == csn_pkg::CSN_OFF_STAT) || (paddr == csn_pkg::CSN_OFF_EVT)
               || (paddr == csn_pkg::CSN_OFF_CNT);
  assign ro_reg = (paddr == csn_pkg::CSN_OFF_STAT) || (paddr == csn_pkg::CSN_OFF_CNT);

  always_comb begin
    pready_d  = 1'b0;
    pslverr_d = 1'b0;
    prdata_d  = prdata;
    if (psel && penable && !pready) begin
      pready_d  = 1'b1;
      pslverr_d = !mapped || (pwrite && ro_reg);
      prdata_d  = 32'h0000_0000;
      case (paddr)
        csn_pkg::CSN_OFF_CTRL: prdata_d[7:0] = ctrl_q;
        csn_pkg::CSN_OFF_TA1:  prdata_d[7:0] = ta1_q;
        csn_pkg::CSN_OFF_GTB:  prdata_d[7:0] = gtb_q;
        csn_pkg::CSN_OFF_SEC:  prdata_d[7:0] = sec_status;
        csn_pkg::CSN_OFF_STAT: prdata_d[23:0] = {feat_w, cur_proto[1:0], cur_fidi, stat_w};
        csn_pkg::CSN_OFF_EVT:  prdata_d[csn_pkg::CSN_EV_NUM-1:0] = evt_q;
        csn_pkg::CSN_OFF_CNT:  prdata_d[15:0] = {warm_cnt_q, cold_cnt_q};
        default:               prdata_d = 32'h0000_0000;
      endcase
    end
  end

  always_comb begin
    ctrl_d     = ctrl_q;
    ta1_d      = ta1_q;
    gtb_d      = gtb_q;
    cold_cnt_d = cold_cnt_q;
    warm_cnt_d = warm_cnt_q;
    if (wr_en && paddr == csn_pkg::CSN_OFF_CTRL) begin
      ctrl_d = pwdata[7:0];
    end
    if (wr_en && paddr == csn_pkg::CSN_OFF_TA1) begin
      ta1_d = pwdata[7:0];
    end
    if (wr_en && paddr == csn_pkg::CSN_OFF_GTB) begin
      gtb_d = pwdata[7:0];
    end
    if (is_cold) begin
      cold_cnt_d = cold_cnt_q + 8'h01;
      warm_cnt_d = 8'h00;
    end
    if (is_warm) begin
      warm_cnt_d = warm_cnt_q + 8'h01;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q     <= csn_pkg::CSN_CTRL_RST;
      ta1_q      <= csn_pkg::CSN_TA1_RST;
      gtb_q      <= csn_pkg::CSN_GTB_RST;
      cold_cnt_q <= 8'h00;
      warm_cnt_q <= 8'h00;
      prdata     <= 32'h0000_0000;
      pready     <= 1'b0;
      pslverr    <= 1'b0;
    end else if (ce) begin
      ctrl_q     <= ctrl_d;
      ta1_q      <= ta1_d;
      gtb_q      <= gtb_d;
      cold_cnt_q <= cold_cnt_d;
      warm_cnt_q <= warm_cnt_d;
      prdata     <= prdata_d;
      pready     <= pready_d;
      pslverr    <= pslverr_d;
    end
  end

  // ---------------------------------------------------------------
  // event flags, write one to clear
  // ---------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < csn_pkg::CSN_EV_NUM; gi++) begin : g_evt
      assign evt_clr[gi] = wr_en && (paddr == csn_pkg::CSN_OFF_EVT) && pwdata[gi];
      csn_flag u_flag (
        .pclk    (pclk),
        .presetn (presetn),
        .ce      (ce),
        .set     (evt_set[gi]),
        .clr     (evt_clr[gi]),
        .flag_q  (evt_q[gi])
      );
    end
  endgenerate

  // ---------------------------------------------------------------
  // answer-to-reset content, frozen at cold reset for the session
  // ---------------------------------------------------------------
  logic [7:0] snap_ctrl_q;
  logic [7:0] snap_ta1_q;
  logic [7:0] snap_tb_q;
  logic [7:0] tb_clean;
  logic [1:0] protos_w;

  // reserved bits and a byte without b8 are never advertised
  always_comb begin
    tb_clean = gtb_q[csn_pkg::CSN_GB_ANY] ? (gtb_q & csn_pkg::CSN_GB_KNOWN) : 8'h00;
  end

  // software may rewrite the registers mid-session; warm resets still
  // replay the snapshot so the answer never changes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      snap_ctrl_q <= csn_pkg::CSN_CTRL_RST;
      snap_ta1_q  <= csn_pkg::CSN_TA1_RST;
      snap_tb_q   <= csn_pkg::CSN_GTB_RST;
    end else if (is_cold) begin
      snap_ctrl_q <= ctrl_q;
      snap_ta1_q  <= ta1_q;
      snap_tb_q   <= ctrl_q[csn_pkg::CSN_CTRL_GLOB_EN] ? tb_clean : 8'h00;
    end
  end

  // no protocol enabled falls back to t=0
  assign protos_w = (snap_ctrl_q[csn_pkg::CSN_CTRL_T0] | snap_ctrl_q[csn_pkg::CSN_CTRL_T1])
                  ? {snap_ctrl_q[csn_pkg::CSN_CTRL_T1], snap_ctrl_q[csn_pkg::CSN_CTRL_T0]}
                  : 2'b01;

  always_comb begin
    feat_w = 6'b00_0000;
    if (snap_tb_q[csn_pkg::CSN_GB_ANY]) begin
      feat_w[0] = snap_tb_q[csn_pkg::CSN_GB_LOWZ];
      feat_w[1] = snap_tb_q[csn_pkg::CSN_GB_USB];
      feat_w[2] = snap_tb_q[csn_pkg::CSN_GB_CLF];
      feat_w[3] = snap_tb_q[csn_pkg::CSN_GB_SCHAN];
      feat_w[4] = snap_tb_q[csn_pkg::CSN_GB_SCHAN] & snap_tb_q[csn_pkg::CSN_GB_P2P];
      feat_w[5] = snap_tb_q[csn_pkg::CSN_GB_EMGT];
    end
  end

  // ---------------------------------------------------------------
  // session state and parameter exchange
  // ---------------------------------------------------------------
  csn_pkg::csn_state_type state_q;
  csn_pkg::csn_state_type state_d;
  logic [7:0] fidi_d;
  logic [3:0] proto_d;
  logic [7:0] sec_d;
  logic       spec_d;
  logic       ndef_d;
  logic       cold_pend_d;
  logic       atr_d;
  logic       done_d;
  logic       acc_d;
  logic       proto_ok;
  logic       f1_ok;
  logic       f2_ok;
  logic       pps_ok;
  logic       pps_take;

  assign proto_ok = (pps_proto == csn_pkg::CSN_PROTO_T0 && protos_w[0])
                 || (pps_proto == csn_pkg::CSN_PROTO_T1 && protos_w[1]);
  assign f1_ok    = !pps1_present || pps1 == snap_ta1_q || pps1 == csn_pkg::CSN_FIDI_DEF;
  assign f2_ok    = !pps2_present || (snap_tb_q[csn_pkg::CSN_GB_ANY]
                 && ((pps2 & ~snap_tb_q) == 8'h00));
  assign pps_ok   = proto_ok & f1_ok & f2_ok;
  assign pps_take = ce & pps_valid & (state_q == csn_pkg::CSN_ST_NEG);
  assign evt_set  = {pps_take & ~pps_ok, pps_take & pps_ok, is_warm, is_cold};

  always_comb begin
    state_d     = state_q;
    fidi_d      = cur_fidi;
    proto_d     = cur_proto;
    sec_d       = sec_status;
    spec_d      = mode_specific;
    ndef_d      = nondefault_ok;
    cold_pend_d = cold_pend_q;
    atr_d       = 1'b0;
    done_d      = 1'b0;
    acc_d       = 1'b0;
    if (wr_en && paddr == csn_pkg::CSN_OFF_SEC) begin
      sec_d = pwdata[7:0];
    end
    case (state_q)
      csn_pkg::CSN_ST_OFF: begin
        if (vcc_rise) begin
          cold_pend_d = 1'b1;
          state_d     = csn_pkg::CSN_ST_HOLD;
        end
      end
      csn_pkg::CSN_ST_HOLD: begin
        if (rst_release) begin
          atr_d       = 1'b1;
          cold_pend_d = 1'b0;
          sec_d       = 8'h00;
          state_d     = csn_pkg::CSN_ST_NEG;
          if (!cold_pend_q && snap_ctrl_q[csn_pkg::CSN_CTRL_WARM_SPC]) begin
            spec_d  = 1'b1;
            state_d = csn_pkg::CSN_ST_RUN;
          end else begin
            spec_d  = 1'b0;
            ndef_d  = 1'b0;
            fidi_d  = csn_pkg::CSN_FIDI_DEF;
            proto_d = protos_w[0] ? csn_pkg::CSN_PROTO_T0 : csn_pkg::CSN_PROTO_T1;
          end
        end
      end
      csn_pkg::CSN_ST_NEG: begin
        if (pps_valid) begin
          done_d = 1'b1;
          if (pps_ok) begin
            acc_d   = 1'b1;
            ndef_d  = 1'b1;
            fidi_d  = pps1_present ? pps1 : csn_pkg::CSN_FIDI_DEF;
            proto_d = pps_proto;
            state_d = csn_pkg::CSN_ST_RUN;
          end
        end
      end
      csn_pkg::CSN_ST_RUN: begin
      end
      default: state_d = csn_pkg::CSN_ST_OFF;
    endcase
    // a reset pulse overrides every state except off; loss of contacts overrides every state
    if (state_q != csn_pkg::CSN_ST_OFF && !rstn_s) begin
      state_d = csn_pkg::CSN_ST_HOLD;
    end
    if (!vcc_s) begin
      state_d     = csn_pkg::CSN_ST_OFF;
      cold_pend_d = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q          <= csn_pkg::CSN_ST_OFF;
      cur_fidi         <= csn_pkg::CSN_FIDI_DEF;
      cur_proto        <= csn_pkg::CSN_PROTO_T0;
      sec_status       <= csn_pkg::CSN_SEC_RST;
      mode_specific    <= 1'b0;
      nondefault_ok    <= 1'b0;
      cold_pend_q      <= 1'b0;
      atr_start        <= 1'b0;
      pps_done         <= 1'b0;
      pps_accept       <= 1'b0;
      atr_ta1          <= csn_pkg::CSN_TA1_RST;
      atr_glob_tb      <= csn_pkg::CSN_GTB_RST;
      atr_glob_present <= 1'b0;
      atr_clkstop_ok   <= 1'b0;
      atr_protos       <= 2'b01;
      char_repeat_en   <= 1'b0;
    end else if (ce) begin
      state_q          <= state_d;
      cur_fidi         <= fidi_d;
      cur_proto        <= proto_d;
      sec_status       <= sec_d;
      mode_specific    <= spec_d;
      nondefault_ok    <= ndef_d;
      cold_pend_q      <= cold_pend_d;
      atr_start        <= atr_d;
      pps_done         <= done_d;
      pps_accept       <= acc_d;
      atr_ta1          <= snap_ta1_q;
      atr_glob_tb      <= snap_tb_q;
      atr_glob_present <= snap_ctrl_q[csn_pkg::CSN_CTRL_GLOB_EN];
      atr_clkstop_ok   <= snap_ctrl_q[csn_pkg::CSN_CTRL_CSTOP]
                        | ~snap_ctrl_q[csn_pkg::CSN_CTRL_CLASS_A];
      atr_protos       <= protos_w;
      char_repeat_en   <= (proto_d == csn_pkg::CSN_PROTO_T0);
    end
  end

  assign stat_w = {3'b000, cold_pend_q, nondefault_ok, mode_specific, state_q};

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  chk_cold_negot: assert property (@(posedge pclk) disable iff (!presetn)
    is_cold && state_q == csn_pkg::CSN_ST_HOLD |=> !mode_specific && sec_status == 8'h00
      && cur_fidi == csn_pkg::CSN_FIDI_DEF)
    else $error("cold reset left specific mode or security set");
  chk_warm_secure: assert property (@(posedge pclk) disable iff (!presetn)
    is_warm && state_q == csn_pkg::CSN_ST_HOLD && vcc_s |=> sec_status == 8'h00)
    else $error("warm reset kept security status");
  chk_warm_keep: assert property (@(posedge pclk) disable iff (!presetn)
    is_warm && state_q == csn_pkg::CSN_ST_HOLD && snap_ctrl_q[csn_pkg::CSN_CTRL_WARM_SPC]
      |=> mode_specific && $stable(cur_fidi) && $stable(cur_proto))
    else $error("specific mode lost rate or protocol");
  chk_atr_same: assert property (@(posedge pclk) disable iff (!presetn)
    is_warm |=> $stable(snap_tb_q) && $stable(snap_ta1_q) && $stable(snap_ctrl_q))
    else $error("answer content changed on warm reset");
  chk_clkstop_cls: assert property (@(posedge pclk) disable iff (!presetn)
    ce && !snap_ctrl_q[csn_pkg::CSN_CTRL_CLASS_A] |=> atr_clkstop_ok)
    else $error("clock stop barred beyond class a");
  chk_pps2_gate: assert property (@(posedge pclk) disable iff (!presetn)
    pps_take && pps2_present && !snap_tb_q[csn_pkg::CSN_GB_ANY] |=> pps_done && !pps_accept)
    else $error("second parameter byte taken without global byte");
  chk_nondef_gate: assert property (@(posedge pclk) disable iff (!presetn)
    cur_fidi != csn_pkg::CSN_FIDI_DEF |-> nondefault_ok)
    else $error("non-default rate without exchange");
  chk_glob_zero: assert property (@(posedge pclk) disable iff (!presetn)
    !snap_tb_q[csn_pkg::CSN_GB_ANY] |-> feat_w == 6'b00_0000 && snap_tb_q == 8'h00)
    else $error("features without b8");
  chk_rep_t0: assert property (@(posedge pclk) disable iff (!presetn)
    ce && state_q == csn_pkg::CSN_ST_RUN && cur_proto == csn_pkg::CSN_PROTO_T0
      ##1 ce |-> char_repeat_en)
    else $error("t0 without character repetition");

endmodule

// *** verification/csn_term_model.sv ***
`timescale 1ns/1ps
module csn_term_model (
  input  wire logic       pclk,
  input  wire logic       pps_done,
  input  wire logic       pps_accept,
  output logic            contact_on_pin,
  output logic            card_rst_n_pin,
  output logic            pps_valid,
  output logic      [3:0] pps_proto,
  output logic            pps1_present,
  output logic      [7:0] pps1,
  output logic            pps2_present,
  output logic      [7:0] pps2
);
  initial begin
    contact_on_pin = 1'b0;
    card_rst_n_pin = 1'b0;
    pps_valid      = 1'b0;
    {pps_proto, pps1_present, pps1, pps2_present, pps2} = '0;
  end
  task automatic pins(input logic pwr, input logic rst_n);
    @(posedge pclk);
    contact_on_pin <= pwr;
    card_rst_n_pin <= rst_n;
  endtask
  // protocol and parameter bytes are inverted once the pulse is over (present flags hold), so a late sample cannot match
  task automatic request(input logic [3:0] pr, input logic [8:0] p1, input logic [8:0] p2,
                         output logic [1:0] res);
    @(posedge pclk);
    pps_valid            <= 1'b1;
    pps_proto            <= pr;
    {pps1_present, pps1} <= p1;
    {pps2_present, pps2} <= p2;
    @(posedge pclk);
    pps_valid <= 1'b0;
    pps_proto <= ~pr;
    pps1      <= ~p1[7:0];
    pps2      <= ~p2[7:0];
    @(posedge pclk);
    res = {pps_done, pps_accept};
  endtask
endmodule

// *** verification/tb_card_session_negotiation.sv ***
`timescale 1ns/1ps
module tb_card_session_negotiation;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err, ce;
  logic [7:0]  paddr, atr_ta1, atr_glob_tb, cur_fidi, sec_status, pps1, pps2;
  logic [31:0] pwdata, prdata, rd;
  logic        contact_on_pin, card_rst_n_pin, pps_valid, pps1_present, pps2_present;
  logic [3:0]  pps_proto, cur_proto;
  logic        atr_start, atr_glob_present, atr_clkstop_ok, pps_done, pps_accept;
  logic        nondefault_ok, char_repeat_en, mode_specific;
  logic [1:0]  atr_protos, res;
  int          miscompares, n_compared, cycles;

  csn_session uut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .contact_on_pin(contact_on_pin), .card_rst_n_pin(card_rst_n_pin),
    .pps_valid(pps_valid), .pps_proto(pps_proto), .pps1_present(pps1_present), .pps1(pps1),
    .pps2_present(pps2_present), .pps2(pps2), .atr_start(atr_start), .atr_ta1(atr_ta1),
    .atr_glob_tb(atr_glob_tb), .atr_glob_present(atr_glob_present),
    .atr_clkstop_ok(atr_clkstop_ok), .atr_protos(atr_protos), .pps_done(pps_done),
    .pps_accept(pps_accept), .cur_fidi(cur_fidi), .cur_proto(cur_proto),
    .nondefault_ok(nondefault_ok), .char_repeat_en(char_repeat_en),
    .sec_status(sec_status), .mode_specific(mode_specific));

  csn_term_model term (.pclk(pclk), .pps_done(pps_done), .pps_accept(pps_accept),
    .contact_on_pin(contact_on_pin), .card_rst_n_pin(card_rst_n_pin),
    .pps_valid(pps_valid), .pps_proto(pps_proto), .pps1_present(pps1_present),
    .pps1(pps1), .pps2_present(pps2_present), .pps2(pps2));

  initial pclk = 1'b0;
  always #50 pclk = ~pclk;

  // -----------------------------------------------------------------
  // bench tasks
  // -----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task report_and_stop();
    if (miscompares == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // no fixed latency assumed: the watchdog ends a hung transfer
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic session(input logic cold);
    int k;
    if (cold) begin
      term.pins(1'b0, 1'b0);
      repeat (4) @(posedge pclk);
    end
    term.pins(1'b1, 1'b0);
    repeat (4) @(posedge pclk);
    term.pins(1'b1, 1'b1);
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (atr_start !== 1'b1 && k < 10);
    check(k, 4);
    // the snapshot outputs register one edge after the start pulse
    @(posedge pclk);
  endtask
  // the terminal may halt the card clock only where the answer allows it
  task automatic clock_stop();
    if (atr_clkstop_ok === 1'b1) begin
      repeat (1860) @(posedge pclk);
      ce <= 1'b0;
      term.request(4'h1, 9'h195, 9'h000, res);
      check(res, 2'b00);
      check(cur_fidi, 8'h11);
      @(posedge pclk);
      ce <= 1'b1;
      repeat (744) @(posedge pclk);
    end
  endtask

  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      miscompares++;
      report_and_stop();
    end
  end

  // -----------------------------------------------------------------
  // main sequence
  // -----------------------------------------------------------------
  initial begin
    {miscompares, n_compared, cycles} = '0;
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    ce = 1'b1;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, csn_pkg::CSN_OFF_CTRL, 0);
    check(rd, 32'h10);
    apb(1'b0, csn_pkg::CSN_OFF_TA1, 0);
    check(rd, 32'h11);
    apb(1'b0, 8'h1c, 0);
    check(err, 1'b1);
    check(rd, 32'h0000_0000);
    apb(1'b1, csn_pkg::CSN_OFF_STAT, 32'hff);
    check(err, 1'b1);
    apb(1'b1, csn_pkg::CSN_OFF_GTB, 32'hfc);
    apb(1'b1, csn_pkg::CSN_OFF_TA1, 32'h95);
    apb(1'b1, csn_pkg::CSN_OFF_CTRL, 32'h35);
    apb(1'b1, csn_pkg::CSN_OFF_SEC, 32'ha5);
    session(1'b1);
    check(sec_status, 8'h00);
    check({atr_glob_present, atr_glob_tb}, 9'h1fc);
    check(atr_clkstop_ok, 1'b1);
    check(atr_protos, 2'b11);
    apb(1'b0, csn_pkg::CSN_OFF_STAT, 0);
    check(rd[23:18], 6'h1f);
    check(rd[2:0], 3'h2);
    check({nondefault_ok, cur_fidi}, 9'h011);
    term.request(4'h2, 9'h195, 9'h000, res);
    check(res, 2'b10);
    term.request(4'h1, 9'h195, 9'h181, res);
    check(res, 2'b10);
    term.request(4'h1, 9'h133, 9'h000, res);
    check(res, 2'b10);
    check(nondefault_ok, 1'b0);
    term.request(4'h1, 9'h195, 9'h190, res);
    check(res, 2'b11);
    check({cur_proto, cur_fidi, nondefault_ok}, 13'h032b);
    check(char_repeat_en, 1'b0);
    apb(1'b1, csn_pkg::CSN_OFF_SEC, 32'h5a);
    session(1'b0);
    check(sec_status, 8'h00);
    check({atr_ta1, atr_glob_tb}, 16'h95fc);
    check(mode_specific, 1'b0);
    clock_stop();
    term.request(4'h0, 9'h111, 9'h000, res);
    check(res, 2'b11);
    check({char_repeat_en, cur_fidi}, 9'h111);
    apb(1'b1, csn_pkg::CSN_OFF_CTRL, 32'h3d);
    session(1'b1);
    term.request(4'h1, 9'h195, 9'h000, res);
    check(res, 2'b11);
    repeat (3) begin
      session(1'b0);
      check({mode_specific, cur_proto, cur_fidi}, 13'h1195);
      check({atr_ta1, atr_glob_tb, atr_clkstop_ok}, 17'h12bf9);
    end
    term.request(4'h1, 9'h195, 9'h000, res);
    check(res, 2'b00);
    apb(1'b1, csn_pkg::CSN_OFF_CTRL, 32'h12);
    session(1'b1);
    check({atr_clkstop_ok, atr_glob_present, atr_glob_tb}, 10'h000);
    check({mode_specific, nondefault_ok, atr_protos}, 4'h1);
    clock_stop();
    term.request(4'h0, 9'h195, 9'h190, res);
    check(res, 2'b10);
    report_and_stop();
  end
endmodule
